/* rtl/watchdog_pkg.sv */
// Purpose: Shared constants and types for the watchdog reset timer
// Assumes: 32-bit Avalon-MM register slave, byte-wide registers in lane 0
// Notes: Offsets are byte addresses of aligned words

package watchdog_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] OFFSET_CONTROL_STATUS = 4'h0;
    localparam logic [3:0] OFFSET_COUNTER = 4'h4;
    localparam logic [3:0] OFFSET_CLOCK_SELECT = 4'h8;

    // ****************************************
    // Control/status and clock select field positions
    // ****************************************
    localparam int BIT_COUNT_ENABLE_WRITE_GUARD = 7;
    localparam int BIT_COUNTER_WRITE_ENABLE = 6;
    localparam int BIT_CONTROL_ENABLE_WRITE_GUARD = 5;
    localparam int BIT_CONTROL_WRITE_ENABLE = 4;
    localparam int BIT_RUN_WRITE_GUARD = 3;
    localparam int BIT_WATCHDOG_RUN = 2;
    localparam int BIT_FLAG_WRITE_GUARD = 1;
    localparam int BIT_RESET_OCCURRED_FLAG = 0;
    localparam int BIT_WATCHDOG_CLOCK_SELECT = 0;

    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [7:0] COUNTER_RESET = 8'h00;
    localparam logic [7:0] COUNTER_MAX = 8'hff;
    localparam logic [7:0] GUARD_READ_MASK = 8'haa;
    localparam int SYSTEM_DIVIDE = 8192;
    localparam int SUBCLOCK_DIVIDE = 32;
    localparam int RESET_HOLD_CYCLES = 512;
    localparam logic [9:0] RESET_HOLD_COUNT = 10'(RESET_HOLD_CYCLES);

    // ****************************************
    // Operating modes
    // ****************************************
    typedef enum logic [2:0] {
        mode_active = 3'b000,
        mode_sleep = 3'b001,
        mode_watch = 3'b010,
        mode_subactive = 3'b011,
        mode_subsleep = 3'b100,
        mode_standby = 3'b101,
        mode_module_standby = 3'b110
    } power_mode_type;

endpackage

/* rtl/prescaler_if.sv */
// Purpose: Carrier between the watchdog core and its prescaler
// Assumes: All signals synchronous to the system clock
// Notes: count_tick is a one-cycle pulse

`timescale 1ns/1ps

interface prescaler_if;
    logic enable;
    logic clock_select;
    logic subclock_tick;
    logic count_tick;

    modport source (
        input enable,
        input clock_select,
        input subclock_tick,
        output count_tick
    );

    modport sink (
        output enable,
        output clock_select,
        output subclock_tick,
        input count_tick
    );
endinterface

/* rtl/watchdog_prescaler.sv */
// Purpose: Divides system clock or subclock ticks into a count enable
// Assumes: subclock_tick is a synchronous one-cycle pulse
// Notes: Both dividers hold while enable is low

`timescale 1ns/1ps

module watchdog_prescaler #(
    parameter int SYSTEM_DIVIDE = watchdog_pkg::SYSTEM_DIVIDE
) (
    input wire logic clock,
    input wire logic rst_n,
    prescaler_if.source link
);

    logic [15:0] system_count;
    logic [4:0] sub_count;
    logic tick;
    wire system_wrap = (system_count == 16'(SYSTEM_DIVIDE - 1));
    wire sub_wrap = link.subclock_tick
        && (sub_count == 5'(watchdog_pkg::SUBCLOCK_DIVIDE - 1));
    wire next_tick = link.enable && (link.clock_select ? sub_wrap : system_wrap);

    // Divider counters
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            system_count <= 16'h0000;
            sub_count <= 5'h00;
            tick <= 1'b0;
        end
        else
        begin
            if (link.enable)
            begin
                system_count <= system_wrap ? 16'h0000 : system_count + 16'h0001;
                if (link.subclock_tick)
                begin
                    sub_count <= sub_count + 5'h01;
                end
            end
            tick <= next_tick;
        end
    end

    // Single-cycle enable
    assign link.count_tick = tick;

endmodule

/* rtl/watchdog_reset_timer.sv */
// Purpose: Eight-bit watchdog that issues an internal reset on overflow
// Assumes: Avalon-MM slave with waitrequest, one wait state per access
// Notes: power_mode selects the low-power behaviour of the counter
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.

`timescale 1ns/1ps

module watchdog_reset_timer #(
    parameter int SYSTEM_DIVIDE = watchdog_pkg::SYSTEM_DIVIDE
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic subclock_tick,
    input wire logic [2:0] power_mode,
    output logic system_reset_request
);

    // ****************************************
    // State
    // ****************************************
    logic [7:0] counter;
    logic counter_write_enable;
    logic control_write_enable;
    logic watchdog_run;
    logic reset_occurred_flag;
    logic watchdog_clock_select;
    logic [9:0] hold_count;

    prescaler_if link ();

    // ****************************************
    // Bus decode
    // ****************************************
    wire [7:0] wbyte = writedata[7:0];
    wire access_done = (read || write) && !waitrequest;
    wire write_done = access_done && write && byteenable[0];
    wire hit_control = (address == watchdog_pkg::OFFSET_CONTROL_STATUS);
    wire hit_counter = (address == watchdog_pkg::OFFSET_COUNTER);
    wire hit_select = (address == watchdog_pkg::OFFSET_CLOCK_SELECT);
    wire write_control = write_done && hit_control;
    wire write_counter = write_done && hit_counter;
    wire write_select = write_done && hit_select;

    // ****************************************
    // Guarded control writes
    // ****************************************
    wire load_counter_enable = write_control
        && !wbyte[watchdog_pkg::BIT_COUNT_ENABLE_WRITE_GUARD];
    wire load_control_enable = write_control
        && !wbyte[watchdog_pkg::BIT_CONTROL_ENABLE_WRITE_GUARD];
    wire load_run = write_control && control_write_enable
        && !wbyte[watchdog_pkg::BIT_RUN_WRITE_GUARD];
    wire clear_flag = write_control && control_write_enable
        && !wbyte[watchdog_pkg::BIT_FLAG_WRITE_GUARD]
        && !wbyte[watchdog_pkg::BIT_RESET_OCCURRED_FLAG];
    wire load_counter = write_counter && counter_write_enable;

    // ****************************************
    // Operating mode gating
    // ****************************************
    wire mode_runs = (power_mode == watchdog_pkg::mode_active)
        || (power_mode == watchdog_pkg::mode_sleep)
        || ((power_mode == watchdog_pkg::mode_subactive) && watchdog_clock_select);
    wire count_step = link.count_tick && watchdog_run && mode_runs;
    wire overflow = count_step && !load_counter && (counter == watchdog_pkg::COUNTER_MAX);

    // ****************************************
    // Next values
    // ****************************************
    wire [7:0] next_counter = load_counter ? wbyte
        : (count_step ? counter + 8'h01 : counter);
    wire next_counter_write_enable = load_counter_enable
        ? wbyte[watchdog_pkg::BIT_COUNTER_WRITE_ENABLE] : counter_write_enable;
    wire next_control_write_enable = load_control_enable
        ? wbyte[watchdog_pkg::BIT_CONTROL_WRITE_ENABLE] : control_write_enable;
    wire next_watchdog_run = load_run
        ? wbyte[watchdog_pkg::BIT_WATCHDOG_RUN] : watchdog_run;
    wire next_reset_occurred_flag = overflow || (reset_occurred_flag && !clear_flag);
    wire next_watchdog_clock_select = write_select
        ? wbyte[watchdog_pkg::BIT_WATCHDOG_CLOCK_SELECT] : watchdog_clock_select;
    wire [9:0] next_hold_count = overflow ? watchdog_pkg::RESET_HOLD_COUNT
        : ((hold_count != 10'h000) ? hold_count - 10'h001 : hold_count);

    wire [7:0] control_image = watchdog_pkg::GUARD_READ_MASK
        | {1'b0, counter_write_enable, 1'b0, control_write_enable,
           1'b0, watchdog_run, 1'b0, reset_occurred_flag};
    wire [7:0] read_byte = hit_control ? control_image
        : (hit_counter ? counter
        : (hit_select ? {7'h00, watchdog_clock_select} : 8'h00));
    wire [31:0] next_readdata = {24'h000000, read_byte};
    wire next_waitrequest = !((read || write) && waitrequest);

    // ****************************************
    // Prescaler
    // ****************************************
    assign link.enable = mode_runs;
    assign link.clock_select = watchdog_clock_select;
    assign link.subclock_tick = subclock_tick;

    watchdog_prescaler #(
        .SYSTEM_DIVIDE(SYSTEM_DIVIDE)
    ) prescaler (
        .clock(clock),
        .rst_n(rst_n),
        .link(link.source)
    );

    // ****************************************
    // Bus slave registers
    // ****************************************
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end
        else
        begin
            waitrequest <= next_waitrequest;
            if (read && waitrequest)
            begin
                readdata <= next_readdata;
            end
        end
    end

    // ****************************************
    // Watchdog registers
    // ****************************************
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            counter <= watchdog_pkg::COUNTER_RESET;
            counter_write_enable <= 1'b0;
            control_write_enable <= 1'b0;
            watchdog_run <= 1'b0;
            reset_occurred_flag <= 1'b0;
            watchdog_clock_select <= 1'b0;
        end
        else
        begin
            counter <= next_counter;
            counter_write_enable <= next_counter_write_enable;
            control_write_enable <= next_control_write_enable;
            watchdog_run <= next_watchdog_run;
            reset_occurred_flag <= next_reset_occurred_flag;
            watchdog_clock_select <= next_watchdog_clock_select;
        end
    end

    // ****************************************
    // Internal reset pulse
    // ****************************************
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hold_count <= 10'h000;
            system_reset_request <= 1'b0;
        end
        else
        begin
            hold_count <= next_hold_count;
            system_reset_request <= (next_hold_count != 10'h000);
        end
    end

    // ****************************************
    // Assertion helpers
    // ****************************************
    logic [9:0] high_run;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            high_run <= 10'h000;
        end
        else
        begin
            high_run <= system_reset_request ? high_run + 10'h001 : 10'h000;
        end
    end

    logic [15:0] tick_gap;
    logic gap_valid;
    wire gap_break = !mode_runs || watchdog_clock_select || write_select;
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_gap <= 16'h0000;
            gap_valid <= 1'b0;
        end
        else
        begin
            tick_gap <= link.count_tick ? 16'h0000 : tick_gap + 16'h0001;
            gap_valid <= !gap_break && (link.count_tick || gap_valid);
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    AST_OVERFLOW_FLAG: assert property (
        overflow |=> reset_occurred_flag && (counter == 8'h00)
            && system_reset_request)
        else $error("Overflow did not set flag and clear counter");

    AST_RESET_HOLD: assert property (
        $fell(system_reset_request) && !$past(overflow) |-> (high_run == 10'd512))
        else $error("Internal reset width is not 512 cycles");

    AST_SYSTEM_DIVIDE: assert property (
        link.count_tick && gap_valid |-> tick_gap == 16'(SYSTEM_DIVIDE - 1))
        else $error("System prescaler period is wrong");

    AST_COUNTER_LOAD: assert property (
        load_counter |=> counter == $past(wbyte))
        else $error("Counter did not take the written value");

    AST_COUNTER_GUARD: assert property (
        write_counter && !counter_write_enable && !count_step |=> $stable(counter))
        else $error("Counter changed on a refused write");

    AST_COUNTER_ENABLE_GUARD: assert property (
        write_control && wbyte[7] |=> $stable(counter_write_enable))
        else $error("Counter write enable changed with guard set");

    AST_CONTROL_ENABLE_GUARD: assert property (
        write_control && wbyte[5] |=> $stable(control_write_enable))
        else $error("Control write enable changed with guard set");

    AST_RUN_LOCK: assert property (
        !control_write_enable ##1 !control_write_enable |-> $stable(watchdog_run))
        else $error("Run bit changed without control write enable");

    AST_RUN_WRITE: assert property (
        load_run |=> watchdog_run == $past(wbyte[2]))
        else $error("Run bit did not follow guarded write");

    AST_GUARD_READ: assert property (
        read && !waitrequest && hit_control |-> (readdata[7:0] & 8'haa) == 8'haa)
        else $error("Guard bits did not read as one");

    AST_STANDBY_HALT: assert property (
        power_mode == watchdog_pkg::mode_standby && !write_counter |=> $stable(counter))
        else $error("Counter moved in standby");

    AST_FLAG_CLEAR: assert property (
        clear_flag && !overflow |=> !reset_occurred_flag)
        else $error("Guarded write did not clear the flag");

    AST_RESET_SOURCE: assert property (
        $rose(system_reset_request) |-> $past(overflow))
        else $error("Internal reset rose without overflow");

    AST_HOLD_START: assert property (
        overflow |=> hold_count == watchdog_pkg::RESET_HOLD_COUNT)
        else $error("Reset hold count not loaded on overflow");

    AST_SUBACTIVE_SOURCE: assert property (
        power_mode == watchdog_pkg::mode_subactive && !watchdog_clock_select
            && !write_counter |=> $stable(counter))
        else $error("Counter moved in subactive on system source");

    AST_COUNT_STEP: assert property (
        count_step && !load_counter && (counter != watchdog_pkg::COUNTER_MAX)
            |=> counter == $past(counter) + 8'h01)
        else $error("Counter did not step by one on a tick");

endmodule

/* verif/testbench.sv */
// Purpose: Self-checking bench for the watchdog reset timer
// Assumes: Avalon-MM slave answers by one waitrequest-low cycle
// Notes: SYSTEM_DIVIDE shortened to 16 for run time

`timescale 1ns/1ps

module testbench;
    localparam int DIV = 16;
    logic clock;
    logic rst_n;
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
    logic [31:0] readdata;
    logic waitrequest;
    logic subclock_tick;
    logic [2:0] power_mode;
    logic system_reset_request;
    int errors;
    int checked;
    int n;
    logic [7:0] rd;
    logic [7:0] a;
    logic [7:0] load;
    logic [7:0] wv [5];
    logic [7:0] ev [5];
    logic [2:0] modes [5];

    watchdog_reset_timer #(.SYSTEM_DIVIDE(DIV)) dut_u (
        .clock(clock),
        .rst_n(rst_n),
        .address(address),
        .read(read),
        .write(write),
        .writedata(writedata),
        .byteenable(byteenable),
        .readdata(readdata),
        .waitrequest(waitrequest),
        .subclock_tick(subclock_tick),
        .power_mode(power_mode),
        .system_reset_request(system_reset_request)
    );

    // ****************************************
    // Clock and helpers
    // ****************************************
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    function automatic logic [7:0] ctrl_exp(input logic cwe, input logic cse, input logic run,
        input logic flag);
        return {1'b1, cwe, 1'b1, cse, 1'b1, run, 1'b1, flag};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] data);
        int k;
        @(posedge clock);
        address <= addr;
        writedata <= {24'h000000, data};
        write <= wr;
        read <= ~wr;
        k = 0;
        do
        begin
            @(posedge clock);
            k++;
        end
        while (waitrequest !== 1'b0 && k < 20);
        if (k >= 20)
            chk(16'h0001, 16'h0000);
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
    endtask

    task automatic end_sim();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        #(8 * 40000);
        errors++;
        end_sim();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        errors = 0;
        checked = 0;
        rst_n = 1'b0;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        byteenable = 4'hf;
        subclock_tick = 1'b0;
        power_mode = 3'h0;
        void'($urandom(32'h1bd9));
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        bus(1'b0, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'h00);
        chk(rd, ctrl_exp(0, 0, 0, 0));
        bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
        chk(rd, 8'h00);
        bus(1'b0, 4'hc, 8'h00);
        chk(rd, 8'h00);
        bus(1'b1, watchdog_pkg::OFFSET_COUNTER, 8'($urandom) | 8'h01);
        bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
        chk(rd, 8'h00);
        // Guarded control writes and their expected readback
        wv = '{8'hf7, 8'h7f, 8'hbf, 8'hdf, 8'hef};
        ev = '{ctrl_exp(0, 0, 0, 0), ctrl_exp(1, 0, 0, 0), ctrl_exp(1, 0, 0, 0),
            ctrl_exp(1, 1, 0, 0), ctrl_exp(1, 1, 0, 0)};
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, watchdog_pkg::OFFSET_CONTROL_STATUS, wv[i]);
            bus(1'b0, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'h00);
            chk(rd, ev[i]);
        end
        // Overflow from a random near-top load
        load = 8'hff - 8'($urandom_range(0, 3));
        bus(1'b1, watchdog_pkg::OFFSET_COUNTER, load);
        bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
        chk(rd, load);
        bus(1'b1, watchdog_pkg::OFFSET_CLOCK_SELECT, 8'h00);
        bus(1'b1, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'hf7);
        n = 0;
        while (system_reset_request !== 1'b1 && n < 5000)
        begin
            @(posedge clock);
            n++;
        end
        chk(16'(n >= (255 - load) * DIV), 16'h1);
        chk(16'(n <= (256 - load) * DIV + 4), 16'h1);
        n = 0;
        while (system_reset_request === 1'b1 && n < 600)
        begin
            @(posedge clock);
            n++;
        end
        chk(16'(n), 16'd512);
        bus(1'b0, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'h00);
        chk(rd, ctrl_exp(1, 1, 1, 1));
        bus(1'b1, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'hfc);
        bus(1'b0, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'h00);
        chk(rd, ctrl_exp(1, 1, 1, 0));
        // Low-power modes other than sleep halt the counter on the system source
        bus(1'b1, watchdog_pkg::OFFSET_COUNTER, 8'h10);
        modes = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6};
        for (int i = 0; i < 5; i++)
        begin
            power_mode <= modes[i];
            bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
            a = rd;
            repeat (100) @(posedge clock);
            bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
            chk(rd, a);
            bus(1'b0, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'h00);
            chk(rd, ctrl_exp(1, 1, 1, 0));
        end
        // Sleep keeps counting on the system source
        power_mode <= 3'h1;
        bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
        a = rd;
        repeat (100) @(posedge clock);
        bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
        chk(16'(rd !== a), 16'h1);
        bus(1'b1, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'hf3);
        bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
        a = rd;
        repeat (100) @(posedge clock);
        bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
        chk(rd, a);
        // Subclock source in subactive mode
        power_mode <= 3'h3;
        bus(1'b1, watchdog_pkg::OFFSET_CLOCK_SELECT, 8'h01);
        bus(1'b1, watchdog_pkg::OFFSET_COUNTER, 8'h00);
        bus(1'b1, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'hf7);
        for (int i = 0; i < 64; i++)
        begin
            @(posedge clock);
            subclock_tick <= 1'b1;
            @(posedge clock);
            subclock_tick <= 1'b0;
            repeat ($urandom_range(1, 4)) @(posedge clock);
        end
        bus(1'b1, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'hf3);
        bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
        chk(rd, 8'h02);
        // Reset in mid-run
        power_mode <= 3'h0;
        bus(1'b1, watchdog_pkg::OFFSET_CLOCK_SELECT, 8'h00);
        bus(1'b1, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'hf7);
        repeat (50) @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        bus(1'b0, watchdog_pkg::OFFSET_CONTROL_STATUS, 8'h00);
        chk(rd, ctrl_exp(0, 0, 0, 0));
        repeat (100) @(posedge clock);
        bus(1'b0, watchdog_pkg::OFFSET_COUNTER, 8'h00);
        chk(rd, 8'h00);
        end_sim();
    end
endmodule
